// ==== rtl/mmu_hwreg_regs.vh ====
`ifndef MMU_HWREG_REGS_VH
`define MMU_HWREG_REGS_VH

// Coprocessor register/select numbers
`define REGNUM_PINNED 5'h06
`define REGNUM_HWENA 5'h07
`define REGNUM_PGRAIN 5'h05
`define SEL_PGRAIN 3'h1
`define SEL_ZERO 3'h0

// Page granularity fields
`define PG_SPE_BIT 28
`define PG_SPLIT_BIT 27
`define PG_RESET 32'h00000000

// Pinned boundary
`define PIN_W 5
`define PIN_RESET 5'h00
`define TB_ENTRIES 32
`define TB_TOP 5'h1F

// Access mask register
`define HW_TLP_BIT 29
`define HW_MASK_W 4
`define HW_RESET 32'h00000000
`define TLP_HWNUM 5'h1D

// Exception codes
`define EXC_LOAD_MISS 5'h02
`define EXC_READ_INH 5'h13
`define EXC_EXEC_INH 5'h14
`define EXC_RESV_INSTR 5'h0A

// Low entry frame field shift when small pages on
`define SMALL_PFN_SHIFT 2

`endif

// ==== rtl/replace_ptr.v ====
`timescale 1ns/1ps
`include "mmu_hwreg_regs.vh"

// Replacement pointer cycling between the pinned boundary and the top entry
module replace_ptr (
   input wire clk,
   input wire nrst,
   input wire reload,
   input wire step,
   input wire [4:0] lower,
   output reg [4:0] ptr_q
);
   reg [4:0] ptr_d;

   always @* begin
      ptr_d = ptr_q;
      if (reload) begin
         ptr_d = `TB_TOP; // RQ11
      end else if (step) begin
         // Wrap back to top entry so pinned slots are never chosen
         if (ptr_q <= lower || ptr_q == 5'h00)
            ptr_d = `TB_TOP; // RQ18
         else
            ptr_d = ptr_q - 5'h01;
      end
   end

   always @(posedge clk) begin
      if (!nrst)
         ptr_q <= `TB_TOP;
      else
         ptr_q <= ptr_d;
   end
endmodule

// ==== rtl/mmu_page_and_hwreg_access_regs.v ====
// Notes on behaviour
// RQ1: Small pages on: low-entry frame field holds address to bit 10, shifted two left.
// RQ2: Small pages on: extra mask bits writable, appended below main mask bits.
// RQ3: Small pages on: vpn extension and address bits 12:11 writable, used in match.
// RQ4: No small-page support present: enable bit ignores writes, reads zero.
// RQ5: Bit 27 clear: inhibit faults use load-miss code; set: dedicated codes.
// RQ6: Reserved bits read zero in all three registers.
// RQ7: Pinned boundary field is bits 4:0, splitting fixed and replaceable entries.
// RQ8: Random-slot write never targets an entry below the boundary.
// RQ9: Indexed-slot write may target any entry.
// RQ10: Pinned boundary clears to zero on reset.
// RQ11: Any boundary write sets the replacement pointer to its top.
// RQ12: Software must keep boundary below entry count; otherwise undefined.
// RQ13: Boundary register exists only with a translation buffer, else reserved.
// RQ14: Access mask bit n lets the hardware-register read reach register n.
// RQ15: Clear mask bit denies that hardware-register read.
// RQ16: Denied hardware-register read raises reserved instruction exception.
// RQ17: Bit 29 enables hardware-register read of the thread-local pointer.
// RQ18: Replacement pointer stays between boundary and top index inclusive.
`timescale 1ns/1ps
`include "mmu_hwreg_regs.vh"

module mmu_page_and_hwreg_access_regs #(
   parameter HAS_TB = 1,
   parameter SMALL_PAGE_PRESENT = 1
) (
   input wire clk,
   input wire nrst,
   // Coprocessor register access
   input wire cop_wr,
   input wire [4:0] cop_reg,
   input wire [2:0] cop_sel,
   input wire [31:0] cop_wdata,
   output reg [31:0] cop_rdata,
   // Translation buffer write instructions
   input wire random_slot_write,
   input wire indexed_slot_write,
   input wire [4:0] index_value,
   output wire slot_write_en,
   output wire [4:0] slot_write_idx,
   output wire [4:0] replace_ptr_out,
   // Small page shaping of entry fields
   input wire [21:0] phys_addr_hi,
   input wire [15:0] page_size_mask_main,
   input wire [1:0] extra_mask_bits,
   input wire [1:0] vpn_extension_in,
   output reg [25:0] phys_frame_field,
   output reg [17:0] entry_dont_care,
   output reg [1:0] vpn_extension,
   output wire small_page_enable,
   // Inhibit fault coding
   input wire read_inhibit_fault,
   input wire exec_inhibit_fault,
   output reg [4:0] inhibit_exc_code,
   // Hardware-register read instruction
   input wire hw_reg_read_instr,
   input wire [4:0] hw_reg_num,
   output wire hw_read_grant,
   output wire hw_read_deny,
   output wire [4:0] hw_read_exc_code
);
   reg spe_q;
   reg split_q;
   reg [4:0] pinned_q;
   reg tlp_q;
   reg [3:0] mask_q;

   function sel_hit;
      input [4:0] r;
      input [2:0] s;
      input [4:0] rw;
      input [2:0] sw;
      begin
         sel_hit = (r == rw) && (s == sw);
      end
   endfunction

   wire wr_pg = cop_wr && sel_hit(cop_reg, cop_sel, `REGNUM_PGRAIN, `SEL_PGRAIN);
   // Without a translation buffer the boundary is reserved
   wire wr_pin = cop_wr && (HAS_TB != 0) &&
      sel_hit(cop_reg, cop_sel, `REGNUM_PINNED, `SEL_ZERO); // RQ13
   wire wr_hw = cop_wr && sel_hit(cop_reg, cop_sel, `REGNUM_HWENA, `SEL_ZERO);

   always @(posedge clk) begin
      if (!nrst) begin
         spe_q <= 1'b0;
         split_q <= 1'b0;
         pinned_q <= `PIN_RESET; // RQ10
         tlp_q <= 1'b0;
         mask_q <= 4'h0;
      end else begin
         if (wr_pg) begin
            spe_q <= (SMALL_PAGE_PRESENT != 0) & cop_wdata[`PG_SPE_BIT]; // RQ4
            split_q <= cop_wdata[`PG_SPLIT_BIT]; // RQ5
         end
         if (wr_pin)
            pinned_q <= cop_wdata[`PIN_W-1:0]; // RQ7
         if (wr_hw) begin
            tlp_q <= cop_wdata[`HW_TLP_BIT]; // RQ17
            mask_q <= cop_wdata[`HW_MASK_W-1:0]; // RQ14
         end
      end
   end

   assign small_page_enable = spe_q;

   // Reserved bits return zero
   always @* begin
      cop_rdata = 32'h00000000; // RQ6
      if (sel_hit(cop_reg, cop_sel, `REGNUM_PGRAIN, `SEL_PGRAIN)) begin
         cop_rdata[`PG_SPE_BIT] = spe_q;
         cop_rdata[`PG_SPLIT_BIT] = split_q;
      end else if (sel_hit(cop_reg, cop_sel, `REGNUM_PINNED, `SEL_ZERO)) begin
         if (HAS_TB != 0)
            cop_rdata[`PIN_W-1:0] = pinned_q; // RQ13
      end else if (sel_hit(cop_reg, cop_sel, `REGNUM_HWENA, `SEL_ZERO)) begin
         cop_rdata[`HW_TLP_BIT] = tlp_q;
         cop_rdata[`HW_MASK_W-1:0] = mask_q;
      end
   end

   // Replacement pointer
   wire [4:0] rptr;
   replace_ptr u_replace_ptr (
      .clk(clk),
      .nrst(nrst),
      .reload(wr_pin), // RQ11
      .step(random_slot_write),
      .lower(pinned_q),
      .ptr_q(rptr)
   );
   assign replace_ptr_out = rptr;

   // Random write clamps to boundary; indexed write reaches any slot
   assign slot_write_en = random_slot_write | indexed_slot_write;
   assign slot_write_idx = indexed_slot_write ? index_value : // RQ9
      ((rptr < pinned_q) ? pinned_q : rptr); // RQ8

   // Small page field shaping
   always @* begin
      if (spe_q) begin
         phys_frame_field = {phys_addr_hi[21:0], 4'h0}; // RQ1
         entry_dont_care = {page_size_mask_main, extra_mask_bits}; // RQ2
         vpn_extension = vpn_extension_in; // RQ3
      end else begin
         phys_frame_field = {2'h0, phys_addr_hi[21:0], 2'h0};
         entry_dont_care = {page_size_mask_main, 2'h3};
         vpn_extension = 2'h0;
      end
   end

   always @* begin
      inhibit_exc_code = `EXC_LOAD_MISS; // RQ5
      if (split_q && read_inhibit_fault)
         inhibit_exc_code = `EXC_READ_INH;
      else if (split_q && exec_inhibit_fault)
         inhibit_exc_code = `EXC_EXEC_INH;
   end

   // Hardware-register read permission
   wire hw_allowed = (hw_reg_num < 5'h04) ? mask_q[hw_reg_num[1:0]] : // RQ14
      (hw_reg_num == `TLP_HWNUM) ? tlp_q : 1'b0; // RQ17
   assign hw_read_grant = hw_reg_read_instr & hw_allowed;
   assign hw_read_deny = hw_reg_read_instr & ~hw_allowed; // RQ15
   assign hw_read_exc_code = hw_read_deny ? `EXC_RESV_INSTR : 5'h00; // RQ16
endmodule

// ==== tb/mmu_regs_sva.sv ====
`timescale 1ns/1ps
module mmu_regs_sva (
   input logic clk,
   input logic nrst,
   input logic cop_wr,
   input logic [4:0] cop_reg,
   input logic [2:0] cop_sel,
   input logic [31:0] cop_wdata,
   input logic [31:0] cop_rdata,
   input logic random_slot_write,
   input logic indexed_slot_write,
   input logic [4:0] index_value,
   input logic slot_write_en,
   input logic [4:0] slot_write_idx,
   input logic [4:0] replace_ptr_out,
   input logic read_inhibit_fault,
   input logic [4:0] inhibit_exc_code,
   input logic hw_reg_read_instr,
   input logic hw_read_deny,
   input logic [4:0] hw_read_exc_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire pin_wr = cop_wr && cop_reg == 5'h06 && cop_sel == 3'h0;
   reg [4:0] pin_q;
   // Shadow of the boundary so bounds need no hierarchy peek
   always @(posedge clk)
      if (!nrst) pin_q <= 5'h00;
      else if (pin_wr) pin_q <= cop_wdata[4:0];
   AST_PIN_PTR: assert property (pin_wr |=> replace_ptr_out == 5'h1F)
      else $error("pointer not at top after boundary write");
   AST_PIN_RSV: assert property (cop_reg == 5'h06 && cop_sel == 3'h0 |-> cop_rdata[31:5] == 0)
      else $error("boundary reserved bits set");
   AST_HW_RSV: assert property (cop_reg == 5'h07 && cop_sel == 3'h0
      |-> cop_rdata[31:30] == 0 && cop_rdata[28:4] == 0)
      else $error("access mask reserved bits set");
   AST_IDX: assert property (indexed_slot_write && !random_slot_write
      |-> slot_write_en && slot_write_idx == index_value)
      else $error("indexed write target wrong");
   AST_RND: assert property (random_slot_write && !indexed_slot_write
      |-> slot_write_en && slot_write_idx >= pin_q)
      else $error("random write below boundary");
   AST_BOUND: assert property ($stable(pin_q) |-> replace_ptr_out >= pin_q)
      else $error("pointer below boundary");
   AST_DENY: assert property (hw_reg_read_instr && hw_read_deny |-> hw_read_exc_code == 5'h0A)
      else $error("denied read without reserved code");
   AST_INH: assert property (read_inhibit_fault
      |-> inhibit_exc_code == 5'h02 || inhibit_exc_code == 5'h13)
      else $error("read inhibit code wrong");
   cover property (pin_wr);
   cover property (random_slot_write);
   cover property (hw_reg_read_instr && hw_read_deny);
endmodule
bind mmu_page_and_hwreg_access_regs mmu_regs_sva i_mmu_regs_sva (.clk, .nrst, .cop_wr,
   .cop_reg, .cop_sel, .cop_wdata, .cop_rdata, .random_slot_write, .indexed_slot_write,
   .index_value, .slot_write_en, .slot_write_idx, .replace_ptr_out, .read_inhibit_fault,
   .inhibit_exc_code, .hw_reg_read_instr, .hw_read_deny, .hw_read_exc_code);

// ==== tb/mmu_page_and_hwreg_access_regs_tb_top.sv ====
`timescale 1ns/1ps
module mmu_page_and_hwreg_access_regs_tb_top;
   logic clk = 0, nrst = 0, cop_wr = 0, rsw = 0, isw = 0, hri = 0, rif = 0, xif = 0;
   logic [4:0] cop_reg = 0, idx = 0, hnum = 0, swi, rpo, iec, hex;
   logic [2:0] cop_sel = 0;
   logic [31:0] wd = 0, rd;
   logic swe, grant, deny, spe;
   logic [21:0] pa = 0;
   logic [15:0] psm = 0;
   logic [1:0] emb = 0, vxi = 0, vxo;
   logic [25:0] pff;
   logic [17:0] edc;
   int err_total = 0, tests_run = 0;
   always #2 clk = ~clk;
   mmu_page_and_hwreg_access_regs i_mmu_page_and_hwreg_access_regs (.clk, .nrst, .cop_wr,
      .cop_reg, .cop_sel, .cop_wdata(wd), .cop_rdata(rd), .random_slot_write(rsw),
      .indexed_slot_write(isw), .index_value(idx), .slot_write_en(swe), .slot_write_idx(swi),
      .replace_ptr_out(rpo), .phys_addr_hi(pa), .page_size_mask_main(psm),
      .extra_mask_bits(emb), .vpn_extension_in(vxi), .phys_frame_field(pff),
      .entry_dont_care(edc), .vpn_extension(vxo), .small_page_enable(spe),
      .read_inhibit_fault(rif),
      .exec_inhibit_fault(xif), .inhibit_exc_code(iec), .hw_reg_read_instr(hri),
      .hw_reg_num(hnum), .hw_read_grant(grant), .hw_read_deny(deny), .hw_read_exc_code(hex));
   task chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(logic [4:0] r, logic [2:0] s, logic [31:0] d);
      @(posedge clk); cop_wr <= 1; cop_reg <= r; cop_sel <= s; wd <= d;
      @(posedge clk); cop_wr <= 0;
   endtask
   task rdc(string n, logic [4:0] r, logic [2:0] s, logic [31:0] e);
      @(posedge clk); cop_reg <= r; cop_sel <= s;
      @(negedge clk); chk(n, e, rd);
   endtask
   task t_regs;
      rdc("pin", 6, 0, 0);
      rdc("hw", 7, 0, 0);
      wr(6, 0, '1);
      rdc("pin", 6, 0, 32'h1F);
      chk("ptr", 31, rpo);
      wr(7, 0, '1);
      rdc("hw", 7, 0, 32'h2000000F);
      wr(5, 1, '1);
      rdc("pg", 5, 1, 32'h18000000);
      chk("spe", 1, spe);
      $display("t_regs done");
   endtask
   task t_slot;
      wr(6, 0, 30);
      repeat (3) begin
         @(posedge clk); rsw <= 1;
         @(negedge clk); chk("rnd", 1, swe && swi >= 30);
         chk("ptr", 1, rpo >= 30);
      end
      @(posedge clk); rsw <= 0; isw <= 1; idx <= 3;
      @(negedge clk); chk("idx", 3, swi);
      @(posedge clk); isw <= 0;
      $display("t_slot done");
   endtask
   task hwr(logic [4:0] n, logic g);
      @(posedge clk); hri <= 1; hnum <= n;
      @(negedge clk); chk("grant", g, grant);
      chk("deny", !g, deny);
      if (!g) chk("exc", 5'h0A, hex);
      @(posedge clk); hri <= 0;
   endtask
   task t_hw;
      wr(7, 0, 32'h20000005);
      hwr(0, 1);
      hwr(1, 0);
      hwr(29, 1);
      hwr(3, 0);
      $display("t_hw done");
   endtask
   task t_small;
      @(posedge clk); pa <= 22'h012345; psm <= 16'hABCD; emb <= 2'h1; vxi <= 2'h2;
      wr(5, 1, 32'h10000000);
      @(negedge clk); chk("pff", 32'h00123450, pff);
      chk("mask", 32'h0002AF35, edc);
      chk("vpnx", 2, vxo);
      wr(5, 1, 0);
      @(negedge clk); chk("pff0", 32'h00048D14, pff);
      chk("mask0", 32'h0002AF37, edc);
      chk("vpnx0", 0, vxo);
      $display("t_small done");
   endtask
   task t_rst;
      wr(6, 0, 5);
      @(posedge clk); nrst <= 0;
      repeat (2) @(posedge clk);
      nrst <= 1;
      rdc("pin_rst", 6, 0, 0);
      chk("ptr_rst", 31, rpo);
      $display("t_rst done");
   endtask
   task inh(logic r, logic x, logic [4:0] e);
      @(posedge clk); rif <= r; xif <= x;
      @(negedge clk); chk("inh", e, iec);
      @(posedge clk); rif <= 0; xif <= 0;
   endtask
   task t_inh;
      wr(5, 1, 0);
      inh(1, 0, 5'h02);
      inh(0, 1, 5'h02);
      wr(5, 1, 32'h08000000);
      inh(1, 0, 5'h13);
      inh(0, 1, 5'h14);
      $display("t_inh done");
   endtask
   task summarize;
      $display("tests %0d bad %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1;
      t_regs;
      t_slot;
      t_hw;
      t_small;
      t_inh;
      t_rst;
      summarize;
   end
   // Run needs about 63 cycles
   initial begin
      #4000;
      err_total++;
      summarize;
   end
endmodule
